// >>> hdl/vsr_top.sv
/*
  Clock source routing, loop power control and oscillator calibration,
  with staged registers, an update strobe and a nonvolatile store.
  Assumes a single-cycle register port master synchronous to sys_clk_i.
*/
// What this block does
// - loop power field zero runs the loop
// - source bit one routes internal oscillator
// - bypass bit zero feeds through divider ratio
// - calibrate bit rising at an update strobe starts calibration unless one is running
// - save config to store, load it at power-up
// - loop power field one powers loop down
// - bypass bit one feeds source straight through
// - source bit zero selects external clock input
`include "vsr_defs.svh"

module vsr_top #(
  parameter int CAL_CYCLES = `VSR_CAL_CYCLES
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   clk_en_i,
  input  wire logic [`VSR_ADDR_W-1:0] reg_addr_i,
  input  wire logic [7:0]             reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [7:0]             reg_rdata_o,
  output logic                        pll_on_o,
  output logic                        pll_pdn_o,
  output logic      [1:0]             loop_pwr_o,
  output logic      [2:0]             ref_en_o,
  output logic                        src_int_osc_o,
  output logic                        div_bypass_o,
  output logic      [2:0]             div_ratio_o,
  output logic                        cal_busy_o,
  output logic                        cal_done_o
);

  localparam int NV_WORDS = 5;
  localparam int CNT_W    = $clog2(CAL_CYCLES + 1);

  // ****************************************
  // address decode
  // ****************************************
  wire logic hit_pwr   = (reg_addr_i == `VSR_OFS_LOOP_PWR);
  wire logic hit_cal   = (reg_addr_i == `VSR_OFS_CAL);
  wire logic hit_ref   = (reg_addr_i == `VSR_OFS_REF_EN);
  wire logic hit_ratio = (reg_addr_i == `VSR_OFS_DIV_RATIO);
  wire logic hit_route = (reg_addr_i == `VSR_OFS_ROUTE);
  wire logic hit_upd   = (reg_addr_i == `VSR_OFS_UPDATE);
  wire logic hit_store = (reg_addr_i == `VSR_OFS_STORE);
  wire logic hit_stat  = (reg_addr_i == `VSR_OFS_STATUS);

  // ****************************************
  // staged and active registers
  // ****************************************
  logic [7:0] stg_q [NV_WORDS];
  logic [7:0] act_q [NV_WORDS];
  logic [7:0] stg_d [NV_WORDS];

  vsr_pkg::vsr_nv_state_t  nv_q;
  vsr_pkg::vsr_cal_state_t cal_q;
  logic [$clog2(NV_WORDS)-1:0] nv_idx_q;
  logic                        nv_first_q;
  logic [CNT_W-1:0]            cal_cnt_q;
  logic                        cal_prev_q;

  wire logic nv_busy   = (nv_q != vsr_pkg::VSR_NV_READY);
  wire logic upd_pulse = reg_wr_i && hit_upd && reg_wdata_i[0] && !nv_busy;
  wire logic save_req  = reg_wr_i && hit_store && reg_wdata_i[0] && !nv_busy;
  wire logic [7:0] nv_rdata;
  wire logic nv_wr     = (nv_q == vsr_pkg::VSR_NV_SAVE);
  wire logic [7:0] nv_wdata = act_q[nv_idx_q];

  // word index of each staged register, shared by write and read paths
  function automatic int unsigned word_of(input logic [`VSR_ADDR_W-1:0] a);
    if (a == `VSR_OFS_LOOP_PWR) begin
      word_of = 0;
    end else if (a == `VSR_OFS_CAL) begin
      word_of = 1;
    end else if (a == `VSR_OFS_REF_EN) begin
      word_of = 2;
    end else if (a == `VSR_OFS_DIV_RATIO) begin
      word_of = 3;
    end else begin
      word_of = 4;
    end
  endfunction : word_of

  wire logic stg_hit = hit_pwr || hit_cal || hit_ref || hit_ratio || hit_route;
  wire logic [2:0] stg_idx = 3'(word_of(reg_addr_i));

  // ****************************************
  // staging writes and boot load into stage
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NV_WORDS; gi++) begin : g_stage
      always_comb begin
        stg_d[gi] = stg_q[gi];
        if (nv_q == vsr_pkg::VSR_NV_LOAD && !nv_first_q && 32'(nv_idx_q) == gi + 1) begin
          stg_d[gi] = nv_rdata;
        end else if (nv_q == vsr_pkg::VSR_NV_LOAD && !nv_first_q && gi == NV_WORDS - 1
                     && 32'(nv_idx_q) == 0) begin
          stg_d[gi] = nv_rdata;
        end else if (reg_wr_i && stg_hit && !nv_busy && 32'(stg_idx) == gi) begin
          stg_d[gi] = reg_wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stg_q[0] <= `VSR_RST_LOOP_PWR;
      stg_q[1] <= `VSR_RST_CAL;
      stg_q[2] <= `VSR_RST_REF_EN;
      stg_q[3] <= `VSR_RST_DIV_RATIO;
      stg_q[4] <= `VSR_RST_ROUTE;
    end else if (clk_en_i) begin
      stg_q <= stg_d;
    end
  end

  // active copy follows stage only on update or end of boot load
  wire logic load_end = (nv_q == vsr_pkg::VSR_NV_LOAD) && !nv_first_q && (nv_idx_q == '0);

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_q[0] <= `VSR_RST_LOOP_PWR;
      act_q[1] <= `VSR_RST_CAL;
      act_q[2] <= `VSR_RST_REF_EN;
      act_q[3] <= `VSR_RST_DIV_RATIO;
      act_q[4] <= `VSR_RST_ROUTE;
    end else if (clk_en_i) begin
      if (load_end) begin
        act_q <= stg_d;
      end else if (upd_pulse) begin
        act_q <= stg_q;
      end
    end
  end

  // ****************************************
  // nonvolatile store: boot load, then save on request
  // ****************************************
  vsr_nvm #(
    .WORDS (NV_WORDS)
  ) u_nvm (
    .sys_clk_i (sys_clk_i),
    .clk_en_i  (clk_en_i),
    .addr_i    (nv_idx_q),
    .wr_i      (nv_wr),
    .wdata_i   (nv_wdata),
    .rdata_o   (nv_rdata)
  );

  // read data lags address by one, so the load walk runs one word behind
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nv_q       <= vsr_pkg::VSR_NV_IDLE;
      nv_idx_q   <= '0;
      nv_first_q <= 1'b1;
    end else if (clk_en_i) begin
      case (nv_q)
        vsr_pkg::VSR_NV_IDLE: begin
          nv_q <= vsr_pkg::VSR_NV_LOAD;
        end
        vsr_pkg::VSR_NV_LOAD: begin
          nv_first_q <= 1'b0;
          if (load_end) begin
            nv_q <= vsr_pkg::VSR_NV_READY;
          end else begin
            nv_idx_q <= (32'(nv_idx_q) == NV_WORDS - 1) ? '0 : nv_idx_q + 1'b1;
          end
        end
        vsr_pkg::VSR_NV_SAVE: begin
          if (32'(nv_idx_q) == NV_WORDS - 1) begin
            nv_q     <= vsr_pkg::VSR_NV_READY;
            nv_idx_q <= '0;
          end else begin
            nv_idx_q <= nv_idx_q + 1'b1;
          end
        end
        vsr_pkg::VSR_NV_READY: begin
          if (save_req) begin
            nv_q     <= vsr_pkg::VSR_NV_SAVE;
            nv_idx_q <= '0;
          end
        end
        default: begin
          nv_q <= vsr_pkg::VSR_NV_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // oscillator calibration
  // ****************************************
  // starts only on a rising calibrate bit at update; holding it high does not rerun
  wire logic cal_start = upd_pulse && stg_q[1][0] && !cal_prev_q;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_q      <= vsr_pkg::VSR_CAL_IDLE;
      cal_cnt_q  <= '0;
      cal_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      if (upd_pulse) begin
        cal_prev_q <= stg_q[1][0];
      end
      case (cal_q)
        vsr_pkg::VSR_CAL_IDLE, vsr_pkg::VSR_CAL_DONE: begin
          if (cal_start) begin
            cal_q     <= vsr_pkg::VSR_CAL_RUN;
            cal_cnt_q <= CNT_W'(CAL_CYCLES - 1);
          end
        end
        vsr_pkg::VSR_CAL_RUN: begin
          if (cal_cnt_q == '0) begin
            cal_q <= vsr_pkg::VSR_CAL_DONE;
          end else begin
            cal_cnt_q <= cal_cnt_q - 1'b1;
          end
        end
        default: begin
          cal_q <= vsr_pkg::VSR_CAL_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // outputs and read port
  // ****************************************
  wire logic [1:0] pwr_f  = act_q[0][1:0];
  wire logic [7:0] status = {4'h0, nv_busy, cal_q == vsr_pkg::VSR_CAL_DONE,
                             cal_q == vsr_pkg::VSR_CAL_RUN, pwr_f == `VSR_PWR_NORMAL};
  wire logic [7:0] rd_mux = stg_hit  ? stg_q[stg_idx] :
                            hit_stat ? status : 8'h00;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o   <= 8'h00;
      pll_on_o      <= 1'b0;
      pll_pdn_o     <= 1'b1;
      loop_pwr_o    <= `VSR_PWR_ASYNC_DOWN;
      ref_en_o      <= 3'h0;
      src_int_osc_o <= 1'b0;
      div_bypass_o  <= 1'b0;
      div_ratio_o   <= 3'h0;
      cal_busy_o    <= 1'b0;
      cal_done_o    <= 1'b0;
    end else if (clk_en_i) begin
      reg_rdata_o   <= reg_rd_i ? rd_mux : 8'h00;
      pll_on_o      <= (pwr_f == `VSR_PWR_NORMAL);
      pll_pdn_o     <= (pwr_f == `VSR_PWR_ASYNC_DOWN);
      loop_pwr_o    <= pwr_f;
      ref_en_o      <= act_q[2][2:0];
      src_int_osc_o <= act_q[4][`VSR_ROUTE_SRC_BIT];
      div_bypass_o  <= act_q[4][`VSR_ROUTE_BYP_BIT];
      div_ratio_o   <= act_q[3][2:0];
      cal_busy_o    <= (cal_q == vsr_pkg::VSR_CAL_RUN);
      cal_done_o    <= (cal_q == vsr_pkg::VSR_CAL_DONE);
    end
  end

endmodule : vsr_top

// >>> hdl/vsr_defs.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  clock source routing and oscillator calibration block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef VSR_DEFS_SVH
`define VSR_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define VSR_ADDR_W         10
`define VSR_OFS_LOOP_PWR   10'h010
`define VSR_OFS_CAL        10'h018
`define VSR_OFS_REF_EN     10'h01C
`define VSR_OFS_DIV_RATIO  10'h1E0
`define VSR_OFS_ROUTE      10'h1E1
`define VSR_OFS_UPDATE     10'h232
`define VSR_OFS_STORE      10'h300
`define VSR_OFS_STATUS     10'h301

// ****************************************
// field positions
// ****************************************
`define VSR_ROUTE_BYP_BIT  0
`define VSR_ROUTE_SRC_BIT  1
`define VSR_STAT_PLL_ON    0
`define VSR_STAT_CAL_BUSY  1
`define VSR_STAT_CAL_DONE  2
`define VSR_STAT_NVM_BUSY  3

// ****************************************
// reset values and encodings
// ****************************************
`define VSR_RST_LOOP_PWR   8'h01
`define VSR_RST_CAL        8'h00
`define VSR_RST_REF_EN     8'h00
`define VSR_RST_DIV_RATIO  8'h00
`define VSR_RST_ROUTE      8'h00
`define VSR_PWR_NORMAL     2'h0
`define VSR_PWR_ASYNC_DOWN 2'h1

// ****************************************
// timing counts
// ****************************************
`define VSR_CLK_MHZ        125
`define VSR_CAL_TIME_US    32
`define VSR_CAL_CYCLES     (`VSR_CAL_TIME_US * `VSR_CLK_MHZ)

`endif

// >>> hdl/vsr_pkg.sv
/*
  Types shared by the routing and calibration block.
  Assumes vsr_defs.svh supplies the numeric constants.
*/
package vsr_pkg;

  typedef enum logic [2:0] {
    VSR_CAL_IDLE = 3'b001,
    VSR_CAL_RUN  = 3'b010,
    VSR_CAL_DONE = 3'b100
  } vsr_cal_state_t;

  typedef enum logic [3:0] {
    VSR_NV_IDLE  = 4'b0001,
    VSR_NV_LOAD  = 4'b0010,
    VSR_NV_SAVE  = 4'b0100,
    VSR_NV_READY = 4'b1000
  } vsr_nv_state_t;

endpackage : vsr_pkg

// >>> hdl/vsr_nvm.sv
/*
  Nonvolatile configuration store model: an array of words with one
  read or write port, written by a save walk and read by a boot load.
  Assumes the owner drives one request per cycle and the clock enable.
*/
module vsr_nvm #(
  parameter int WORDS = 5
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     clk_en_i,
  input  wire logic [$clog2(WORDS)-1:0] addr_i,
  input  wire logic                     wr_i,
  input  wire logic [7:0]               wdata_i,
  output logic      [7:0]               rdata_o
);

  // ****************************************
  // storage, no reset: contents survive a chip reset
  // ****************************************
  logic [7:0] mem [WORDS];

  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (wr_i) begin
        mem[addr_i] <= wdata_i;
      end
      rdata_o <= mem[addr_i];
    end
  end

endmodule : vsr_nvm

// >>> dv/vsr_top_monitor.sv
/*
  Port checker for the routing and calibration block, bound to vsr_top.
  Assumes the register port master and the CAL_CYCLES of the bound instance.
*/
`include "vsr_defs.svh"

module vsr_top_monitor #(
  parameter int CAL_CYCLES = `VSR_CAL_CYCLES
) (
  input wire logic                   sys_clk_i,
  input wire logic                   sys_rst_i,
  input wire logic                   clk_en_i,
  input wire logic [`VSR_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0]             reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [7:0]             reg_rdata_o,
  input wire logic                   pll_on_o,
  input wire logic                   pll_pdn_o,
  input wire logic [1:0]             loop_pwr_o,
  input wire logic [2:0]             ref_en_o,
  input wire logic                   src_int_osc_o,
  input wire logic                   div_bypass_o,
  input wire logic [2:0]             div_ratio_o,
  input wire logic                   cal_busy_o,
  input wire logic                   cal_done_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ****************************************
  // helper state
  // ****************************************
  logic [3:0]  boot_q;
  logic [15:0] busy_q;
  logic        cal_stg_q;
  logic        cal_prev_q;
  // boot load settles well inside 15 cycles
  wire booted = boot_q == 4'hF;
  wire upd    = booted && clk_en_i && reg_wr_i && reg_addr_i == `VSR_OFS_UPDATE && reg_wdata_i[0];
  wire cal_wr = booted && clk_en_i && reg_wr_i && reg_addr_i == `VSR_OFS_CAL;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      boot_q     <= 4'h0;
      busy_q     <= 16'h0000;
      cal_stg_q  <= 1'b0;
      cal_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      // helpers freeze with the block, else counts drift while enable is low
      boot_q     <= booted ? boot_q : boot_q + 4'h1;
      busy_q     <= cal_busy_o ? busy_q + 16'h0001 : 16'h0000;
      cal_stg_q  <= cal_wr ? reg_wdata_i[0] : cal_stg_q;
      cal_prev_q <= upd ? cal_stg_q : cal_prev_q;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  pwr_on_a: assert property (loop_pwr_o == `VSR_PWR_NORMAL |-> pll_on_o && !pll_pdn_o)
    else $error("loop power zero without loop running");
  pwr_down_a: assert property (loop_pwr_o == `VSR_PWR_ASYNC_DOWN |-> pll_pdn_o && !pll_on_o)
    else $error("loop power one without power down");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  staged_hold_a: assert property (booted && $changed({loop_pwr_o, ref_en_o, src_int_osc_o,
    div_bypass_o, div_ratio_o}) |-> $past(upd, 2)) else $error("output moved without update");
  cal_start_a: assert property (upd && cal_stg_q && !cal_prev_q |-> ##2 cal_busy_o)
    else $error("calibration did not start");
  cal_again_a: assert property (upd && cal_prev_q && !cal_busy_o |-> ##2 !cal_busy_o)
    else $error("calibration restarted without clear");
  cal_len_a: assert property ($fell(cal_busy_o) |->
    busy_q == 16'(CAL_CYCLES) ##[0:1] cal_done_o) else $error("calibration length wrong");
  done_hold_a: assert property ($fell(cal_done_o) |-> ##[0:2] cal_busy_o)
    else $error("done dropped without new start");

  cover property (upd && cal_stg_q && !cal_prev_q);
  cover property ($fell(cal_busy_o));
  cover property (reg_rdata_o != 8'h00);
endmodule : vsr_top_monitor

bind vsr_top vsr_top_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pll_on_o(pll_on_o),
  .pll_pdn_o(pll_pdn_o), .loop_pwr_o(loop_pwr_o), .ref_en_o(ref_en_o),
  .src_int_osc_o(src_int_osc_o), .div_bypass_o(div_bypass_o),
  .div_ratio_o(div_ratio_o), .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o));

// >>> dv/testbench.sv
/*
  Self-checking bench for the routing and calibration block.
  Assumes the port checker is bound from its own file.
*/
`include "vsr_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAL = 8;
  logic       sys_clk_i   = 1'b0;
  logic       sys_rst_i   = 1'b1;
  logic       clk_en_i    = 1'b1;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [9:0] reg_addr_i  = 10'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic       pll_on_o, pll_pdn_o, src_int_osc_o, div_bypass_o, cal_busy_o, cal_done_o;
  logic [1:0] loop_pwr_o;
  logic [2:0] ref_en_o, div_ratio_o;
  int         fails = 0, compares = 0, cyc = 0, n;
  // nibbles: power, ref enable, ratio, route, expected loop on
  logic [19:0] rows [4] = '{20'h07521, 20'h11010, 20'h02331, 20'h14600};
  wire [15:0] outv = {6'h00, loop_pwr_o, ref_en_o, div_ratio_o, src_int_osc_o, div_bypass_o};

  vsr_top #(.CAL_CYCLES(CAL)) u_dut (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pll_on_o(pll_on_o),
    .pll_pdn_o(pll_pdn_o), .loop_pwr_o(loop_pwr_o), .ref_en_o(ref_en_o),
    .src_int_osc_o(src_int_osc_o), .div_bypass_o(div_bypass_o),
    .div_ratio_o(div_ratio_o), .cal_busy_o(cal_busy_o), .cal_done_o(cal_done_o));

  initial begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] ev(input logic [19:0] r);
    return {6'h00, r[17:16], r[14:12], r[10:8], r[5:4]};
  endfunction : ev

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // read data is sampled just after the edge that took the strobe
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= w;
    reg_rd_i    <= !w;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
  endtask : bus

  task automatic commit;
    bus(1'b1, `VSR_OFS_UPDATE, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : commit

  task automatic apply(input logic [19:0] r);
    bus(1'b1, `VSR_OFS_LOOP_PWR, 8'(r[19:16]));
    bus(1'b1, `VSR_OFS_REF_EN, 8'(r[15:12]));
    bus(1'b1, `VSR_OFS_DIV_RATIO, 8'(r[11:8]));
    bus(1'b1, `VSR_OFS_ROUTE, 8'(r[7:4]));
    bus(1'b0, `VSR_OFS_ROUTE, 8'h00);
    chk(16'(reg_rdata_o), 16'(r[7:4]));
  endtask : apply

  task automatic rst;
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1;
    chk(outv, 16'h0100);
    chk(16'({pll_on_o, pll_pdn_o}), 16'h0001);
    chk(16'({cal_busy_o, cal_done_o, reg_rdata_o}), 16'h0000);
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    $display("test reset done");
  endtask : rst

  task automatic end_sim;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // ****************************************
  // sequence
  // ****************************************
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end

  initial begin
    rst();
    // store is blank at first boot: give the calibrate bit a known value
    bus(1'b1, `VSR_OFS_CAL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      apply(rows[i]);
      if (i > 0)
        chk(outv, ev(rows[i - 1]));
      commit();
      chk(outv, ev(rows[i]));
      chk(16'({pll_on_o, pll_pdn_o}), 16'({rows[i][0], rows[i][16]}));
    end
    $display("test routing table done");
    bus(1'b1, `VSR_OFS_CAL, 8'h01);
    bus(1'b1, `VSR_OFS_UPDATE, 8'h01);
    @(posedge sys_clk_i);
    #1;
    n = 0;
    while (cal_busy_o === 1'b1 && n < 100) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(16'(n), 16'(CAL));
    @(posedge sys_clk_i);
    #1;
    chk(16'({cal_busy_o, cal_done_o}), 16'h0001);
    commit();
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(16'({cal_busy_o, cal_done_o}), 16'h0001);
    bus(1'b1, `VSR_OFS_CAL, 8'h00);
    commit();
    bus(1'b1, `VSR_OFS_CAL, 8'h01);
    bus(1'b1, `VSR_OFS_UPDATE, 8'h01);
    @(posedge sys_clk_i);
    #1;
    chk(16'(cal_busy_o), 16'h0001);
    repeat (12) @(posedge sys_clk_i);
    bus(1'b0, `VSR_OFS_STATUS, 8'h00);
    chk(16'(reg_rdata_o), 16'h0004);
    bus(1'b0, 10'h3FF, 8'h00);
    chk(16'(reg_rdata_o), 16'h0000);
    $display("test calibration done");
    bus(1'b1, `VSR_OFS_CAL, 8'h00);
    apply(rows[0]);
    commit();
    bus(1'b1, `VSR_OFS_STORE, 8'h01);
    repeat (8) @(posedge sys_clk_i);
    rst();
    #1;
    chk(outv, ev(rows[0]));
    chk(16'({pll_on_o, pll_pdn_o}), 16'h0002);
    bus(1'b0, `VSR_OFS_ROUTE, 8'h00);
    chk(16'(reg_rdata_o), 16'(rows[0][7:4]));
    $display("test store and boot done");
    // strobes while the enable is low must leave stage and outputs alone
    @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    bus(1'b1, `VSR_OFS_ROUTE, 8'h03);
    bus(1'b1, `VSR_OFS_UPDATE, 8'h01);
    @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    #1;
    chk(outv, ev(rows[0]));
    bus(1'b0, `VSR_OFS_ROUTE, 8'h00);
    chk(16'(reg_rdata_o), 16'(rows[0][7:4]));
    $display("test clock enable done");
    end_sim();
  end
endmodule : testbench
